//--- design/scr_core.sv
// speed command rate limiter with acceleration and braking feedforward
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module scr_core
  import scr_pkg::*;
#(
  parameter int TICK_CYCLES = SCR_TICK_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic        [15:0] reg_addr,
  input  wire logic        [15:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic             [15:0] reg_rdata,
  input  wire logic signed [15:0] throttle_cmd,
  input  wire logic        [15:0] brake_cmd,
  input  wire logic signed [15:0] measured_speed,
  output logic signed      [15:0] speed_setpoint,
  output logic signed      [15:0] ff_current,
  output logic                    accel_ff_active,
  output logic                    brake_ff_active
);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  typedef struct packed {
    scr_state_t                   st;
    logic [31:0]                  tick_cnt;
    logic [2:0]                   job;
    logic                         div_start;
    logic [SCR_NREG-1:0][15:0]    cfg;
    logic [15:0]                  rdata;
    logic signed [15:0]           thr_s;
    logic signed [15:0]           spd_s;
    logic [15:0]                  brk_s;
    logic [15:0]                  band_f;
    logic [5:0][31:0]             step;
    logic signed [31:0]           sp_q;
    scr_mode_t                    mode;
    logic                         accel_on;
    logic                         brake_on;
    logic                         dir_neg;
    logic                         ramp_go;
    logic signed [15:0]           speed_setpoint;
    logic signed [15:0]           ff_current;
  } scr_core_state_t;

  logic [1:0]      rst_pipe;
  logic            rst_n_sync;
  scr_core_state_t q;
  scr_core_state_t n;
  logic [31:0]     div_num;
  logic [15:0]     div_den;
  logic            div_done;
  logic [31:0]     div_quot;
  logic [15:0]     acc_lvl;
  logic [15:0]     brk_lvl;

  // reset is asserted at once and released only after two clean edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe[1];

  // returns {hit, index} of a configuration address
  function automatic logic [4:0] scr_decode(input logic [15:0] addr);
    logic [4:0] res;
    res = '0;
    for (int i = 0; i < SCR_NREG; i++) begin
      if (addr == SCR_REG_ADDR[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : scr_decode

  always_comb begin
    logic [4:0]         dec;
    logic [15:0]        typ;
    logic [15:0]        ls_rpm;
    logic [15:0]        hs_rpm;
    logic [15:0]        spd_mag;
    logic [15:0]        thr_mag;
    logic [15:0]        cmd_mag;
    logic signed [15:0] cmd_int;
    logic               dir_neg;
    logic               thr_opp;
    logic [15:0]        tgt_mag;
    logic signed [15:0] tgt;
    logic [15:0]        brk_frac;
    logic [15:0]        full_t;
    logic [15:0]        time_ms;
    scr_mode_t          mode;
    logic signed [32:0] diff;
    logic [32:0]        diff_mag;
    logic [32:0]        step33;
    logic signed [31:0] sp_new;
    logic signed [16:0] ff_mag;
    // locals that only some branches set start from a harmless value
    dir_neg = 1'b0;
    time_ms = '0;
    sp_new = '0;
    mode = SCR_COAST;
    dec = scr_decode(reg_addr);
    typ = q.cfg[SCR_I_TYP_MAX];
    ls_rpm = scr_scale(typ, q.cfg[SCR_I_LS_THR]);
    hs_rpm = scr_scale(typ, q.cfg[SCR_I_HS_THR]);
    spd_mag = scr_mag(q.spd_s);
    thr_mag = scr_mag(q.thr_s);
    cmd_int = q.sp_q[31:16];
    cmd_mag = scr_mag(cmd_int);
    // travel direction: measured speed first, then command, then throttle
    if (q.spd_s != '0) begin
      dir_neg = q.spd_s[15];
    end else if (cmd_int != '0) begin
      dir_neg = cmd_int[15];
    end else begin
      dir_neg = q.thr_s[15];
    end
    thr_opp = (q.thr_s != '0) && (q.thr_s[15] != dir_neg) && (q.spd_s != '0);
    tgt_mag = scr_scale(typ, thr_mag);
    tgt = q.thr_s[15] ? -$signed(tgt_mag) : $signed(tgt_mag);
    brk_frac = scr_mag(q.brk_s);
    if (thr_opp && (thr_mag > brk_frac)) begin
      brk_frac = thr_mag;
    end
    full_t = '0;
    if ((q.brk_s != '0) || thr_opp) begin
      mode = SCR_BRAKE;
      full_t = scr_lerp(q.cfg[SCR_I_FB_LS], q.cfg[SCR_I_FB_HS], q.band_f);
      time_ms = scr_lerp(q.cfg[SCR_I_SMALL_BRK], full_t, brk_frac);
      if (q.brk_s != '0) begin
        tgt = '0;
      end
    end else if (q.thr_s == '0) begin
      mode = SCR_COAST;
      time_ms = scr_lerp(q.cfg[SCR_I_COAST_LS], q.cfg[SCR_I_COAST_HS], q.band_f);
    end else if ((tgt_mag > cmd_mag) || ((cmd_int != '0) && (cmd_int[15] != q.thr_s[15]))) begin
      mode = SCR_ACCEL;
      full_t = scr_lerp(q.cfg[SCR_I_FA_LS], q.cfg[SCR_I_FA_HS], q.band_f);
      time_ms = scr_lerp(q.cfg[SCR_I_SMALL_THR], full_t, thr_mag);
    end else begin
      mode = SCR_REDUCE;
      time_ms = q.cfg[SCR_I_REDUCED];
    end

    // one shared divider serves the band fraction, the slope and four ramp steps
    case (q.job)
      SCR_JOB_BAND: begin
        div_num = 32'(spd_mag - ls_rpm) << SCR_Q15;
        div_den = (hs_rpm > ls_rpm) ? hs_rpm - ls_rpm : 16'h0001;
      end
      SCR_JOB_RATE: begin
        div_num = {typ, SCR_FRAC_PAD};
        div_den = time_ms;
      end
      SCR_JOB_ACC_BUILD: begin
        div_num = {q.cfg[SCR_I_ACC_FF], SCR_FRAC_PAD};
        div_den = q.cfg[SCR_I_BUILD];
      end
      SCR_JOB_ACC_REL: begin
        div_num = {q.cfg[SCR_I_ACC_FF], SCR_FRAC_PAD};
        div_den = q.cfg[SCR_I_RELEASE];
      end
      SCR_JOB_BRK_BUILD: begin
        div_num = {q.cfg[SCR_I_BRK_FF], SCR_FRAC_PAD};
        div_den = q.cfg[SCR_I_BUILD];
      end
      default: begin
        div_num = {q.cfg[SCR_I_BRK_FF], SCR_FRAC_PAD};
        div_den = q.cfg[SCR_I_RELEASE];
      end
    endcase

    // the target is signed: zero-extending it would ramp reverse commands the wrong way
    diff = 33'($signed({tgt, SCR_FRAC_PAD})) - 33'(q.sp_q);
    diff_mag = diff[32] ? 33'(-diff) : 33'(diff);
    step33 = {1'b0, q.step[SCR_JOB_RATE]};
    if (diff_mag <= step33) begin
      sp_new = {tgt, SCR_FRAC_PAD};
    end else if (diff[32]) begin
      sp_new = 32'(33'(q.sp_q) - step33);
    end else begin
      sp_new = 32'(33'(q.sp_q) + step33);
    end

    n = q;
    n.div_start = 1'b0;
    n.ramp_go = 1'b0;
    n.rdata = '0;
    n.tick_cnt = (q.tick_cnt == TICK_LAST) ? '0 : q.tick_cnt + 32'h0000_0001;

    if (reg_wr && dec[4]) begin
      n.cfg[dec[3:0]] = reg_wdata;
    end
    // read data stand only in the cycle after the strobe; unmapped reads give zero
    if (reg_rd) begin
      if (dec[4]) begin
        n.rdata = q.cfg[dec[3:0]];
      end else if (reg_addr == SCR_ADDR_STAT_SPEED) begin
        n.rdata = q.speed_setpoint;
      end else if (reg_addr == SCR_ADDR_STAT_FF) begin
        n.rdata = q.ff_current;
      end else if (reg_addr == SCR_ADDR_STAT_MODE) begin
        n.rdata = {11'h000, q.dir_neg, q.brake_on, q.accel_on, q.mode};
      end
    end

    case (q.st)
      SCR_IDLE: begin
        if (q.tick_cnt == TICK_LAST) begin
          n.thr_s = throttle_cmd;
          n.brk_s = brake_cmd;
          n.spd_s = measured_speed;
          n.job = SCR_JOB_BAND;
          n.div_start = 1'b1;
          n.st = SCR_WAIT;
        end
      end
      SCR_WAIT: begin
        if (div_done) begin
          n.step[q.job] = div_quot;
          if (q.job == SCR_JOB_BAND) begin
            if (spd_mag <= ls_rpm) begin
              n.band_f = '0;
            end else if (spd_mag >= hs_rpm) begin
              n.band_f = SCR_FULL_FRAC;
            end else begin
              n.band_f = (div_quot > 32'(SCR_FULL_FRAC)) ? SCR_FULL_FRAC : div_quot[15:0];
            end
          end
          if (q.job == SCR_JOB_BRK_REL) begin
            n.st = SCR_APPLY;
          end else begin
            n.job = q.job + 3'h1;
            n.div_start = 1'b1;
          end
        end
      end
      SCR_APPLY: begin
        n.sp_q = sp_new;
        n.speed_setpoint = sp_new[31:16];
        n.mode = mode;
        n.dir_neg = dir_neg;
        n.accel_on = (mode == SCR_ACCEL) && (diff != '0);
        n.brake_on = (mode != SCR_ACCEL) && (diff != '0);
        n.ramp_go = 1'b1;
        n.st = SCR_IDLE;
      end
      default: begin
        n.st = SCR_IDLE;
      end
    endcase

    // accel term pushes along travel, brake term against it
    ff_mag = $signed({1'b0, acc_lvl}) - $signed({1'b0, brk_lvl});
    n.ff_current = q.dir_neg ? 16'(-ff_mag) : 16'(ff_mag);
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      q <= '0;
      for (int i = 0; i < SCR_NREG; i++) begin
        q.cfg[i] <= SCR_REG_RESET[i];
      end
    end else begin
      q <= n;
    end
  end

  scr_divider #(
    .NUM_W (32),
    .DEN_W (16)
  ) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n_sync),
    .start    (q.div_start),
    .num      (div_num),
    .den      (div_den),
    .done     (div_done),
    .quot     (div_quot)
  );

  scr_ff_ramp u_acc_ramp (
    .core_clk     (core_clk),
    .rst_n        (rst_n_sync),
    .apply        (q.ramp_go),
    .build        (q.accel_on),
    .limit        (q.cfg[SCR_I_ACC_FF]),
    .build_step   (q.step[SCR_JOB_ACC_BUILD]),
    .release_step (q.step[SCR_JOB_ACC_REL]),
    .level        (acc_lvl)
  );

  scr_ff_ramp u_brk_ramp (
    .core_clk     (core_clk),
    .rst_n        (rst_n_sync),
    .apply        (q.ramp_go),
    .build        (q.brake_on),
    .limit        (q.cfg[SCR_I_BRK_FF]),
    .build_step   (q.step[SCR_JOB_BRK_BUILD]),
    .release_step (q.step[SCR_JOB_BRK_REL]),
    .level        (brk_lvl)
  );

  assign reg_rdata       = q.rdata;
  assign speed_setpoint  = q.speed_setpoint;
  assign ff_current      = q.ff_current;
  assign accel_ff_active = q.accel_on;
  assign brake_ff_active = q.brake_on;
endmodule : scr_core

//--- design/scr_pkg.sv
// shared constants, types and helpers of the speed command ramp block
package scr_pkg;
  localparam int SCR_CLK_PERIOD_NS = 10;
  localparam int SCR_TICK_US       = 1000;
  localparam int SCR_TICK_CYCLES   = SCR_TICK_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_Q15           = 15;
  localparam int SCR_Q16           = 16;
  localparam logic [15:0] SCR_FULL_FRAC = 16'h7fff;
  localparam logic [15:0] SCR_FRAC_PAD  = 16'h0000;

  localparam int SCR_NREG        = 16;
  localparam int SCR_I_BUILD     = 0;
  localparam int SCR_I_RELEASE   = 1;
  localparam int SCR_I_FA_HS     = 2;
  localparam int SCR_I_FA_LS     = 3;
  localparam int SCR_I_FB_HS     = 4;
  localparam int SCR_I_FB_LS     = 5;
  localparam int SCR_I_ACC_FF    = 6;
  localparam int SCR_I_BRK_FF    = 7;
  localparam int SCR_I_SMALL_THR = 8;
  localparam int SCR_I_COAST_HS  = 9;
  localparam int SCR_I_COAST_LS  = 10;
  localparam int SCR_I_REDUCED   = 11;
  localparam int SCR_I_SMALL_BRK = 12;
  localparam int SCR_I_HS_THR    = 13;
  localparam int SCR_I_LS_THR    = 14;
  localparam int SCR_I_TYP_MAX   = 15;

  localparam logic [15:0] SCR_REG_ADDR [SCR_NREG] = '{
    16'h3808, 16'h3809, 16'h381d, 16'h381e, 16'h381f, 16'h3820, 16'h3828, 16'h3829,
    16'h3834, 16'h383c, 16'h383d, 16'h3843, 16'h3850, 16'h3107, 16'h3109, 16'h3870};
  localparam logic [15:0] SCR_REG_RESET [SCR_NREG] = '{
    16'h03e8, 16'h0190, 16'h1388, 16'h09c4, 16'h03e8, 16'h07d0, 16'h0000, 16'h0000,
    16'h2710, 16'h2710, 16'h4e20, 16'h7530, 16'h0fa0, 16'h5999, 16'h2666, 16'h0fa0};

  localparam logic [15:0] SCR_ADDR_STAT_SPEED = 16'h3880;
  localparam logic [15:0] SCR_ADDR_STAT_FF    = 16'h3881;
  localparam logic [15:0] SCR_ADDR_STAT_MODE  = 16'h3882;

  localparam logic [2:0] SCR_JOB_BAND      = 3'h0;
  localparam logic [2:0] SCR_JOB_RATE      = 3'h1;
  localparam logic [2:0] SCR_JOB_ACC_BUILD = 3'h2;
  localparam logic [2:0] SCR_JOB_ACC_REL   = 3'h3;
  localparam logic [2:0] SCR_JOB_BRK_BUILD = 3'h4;
  localparam logic [2:0] SCR_JOB_BRK_REL   = 3'h5;

  typedef enum logic [1:0] {SCR_ACCEL, SCR_REDUCE, SCR_COAST, SCR_BRAKE} scr_mode_t;
  typedef enum logic [1:0] {SCR_IDLE, SCR_WAIT, SCR_APPLY} scr_state_t;

  // magnitude of a signed value, saturated to the full-scale fraction
  function automatic logic [15:0] scr_mag(input logic signed [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : 16'(v);
    return (m > SCR_FULL_FRAC) ? SCR_FULL_FRAC : m;
  endfunction : scr_mag

  // a times a q15 fraction
  function automatic logic [15:0] scr_scale(input logic [15:0] a, input logic [15:0] f);
    logic [31:0] p;
    p = 32'(a) * 32'(f);
    return 16'(p >> SCR_Q15);
  endfunction : scr_scale

  // linear blend from a (f = 0) to b (f = full scale)
  function automatic logic [15:0] scr_lerp(input logic [15:0] a, input logic [15:0] b,
                                           input logic [15:0] f);
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    diff = $signed({1'b0, b}) - $signed({1'b0, a});
    prod = 34'(diff) * 34'($signed({1'b0, f}));
    return 16'($signed({1'b0, a}) + 17'(prod >>> SCR_Q15));
  endfunction : scr_lerp
endpackage : scr_pkg

//--- design/scr_divider.sv
// sequential unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module scr_divider
  import scr_pkg::*;
#(
  parameter int NUM_W = 32,
  parameter int DEN_W = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] num,
  input  wire logic [DEN_W-1:0] den,
  output logic                  done,
  output logic      [NUM_W-1:0] quot
);
  typedef struct packed {
    logic                     busy;
    logic [$clog2(NUM_W)-1:0] cnt;
    logic [NUM_W-1:0]         q;
    logic [DEN_W:0]           r;
    logic [DEN_W-1:0]         d;
    logic                     done;
  } scr_div_state_t;

  scr_div_state_t q;
  scr_div_state_t n;

  // a zero divisor yields all ones, which callers treat as saturation
  always_comb begin
    logic [DEN_W:0] r2;
    r2 = '0;
    n = q;
    n.done = 1'b0;
    if (start) begin
      n.busy = 1'b1;
      n.cnt = '0;
      n.q = num;
      n.r = '0;
      n.d = den;
    end else if (q.busy) begin
      r2 = {q.r[DEN_W-1:0], q.q[NUM_W-1]};
      if (r2 >= {1'b0, q.d}) begin
        n.r = r2 - {1'b0, q.d};
        n.q = {q.q[NUM_W-2:0], 1'b1};
      end else begin
        n.r = r2;
        n.q = {q.q[NUM_W-2:0], 1'b0};
      end
      n.cnt = q.cnt + 1'b1;
      if (q.cnt == ($clog2(NUM_W))'(NUM_W - 1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done = q.done;
  assign quot = q.q;
endmodule : scr_divider

//--- design/scr_ff_ramp.sv
// linear build and release ramp of one feedforward current term
`timescale 1ns/1ps
module scr_ff_ramp
  import scr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        apply,
  input  wire logic        build,
  input  wire logic [15:0] limit,
  input  wire logic [31:0] build_step,
  input  wire logic [31:0] release_step,
  output logic      [15:0] level
);
  typedef struct packed {
    logic [31:0] lvl;
  } scr_ramp_state_t;

  scr_ramp_state_t q;
  scr_ramp_state_t n;

  always_comb begin
    logic [31:0] tgt;
    logic [32:0] up;
    logic [31:0] rel;
    tgt = build ? {limit, SCR_FRAC_PAD} : '0;
    up = 33'(q.lvl) + 33'(build_step);
    // a zero release step only occurs with a zero limit: drop at once
    rel = (release_step == '0) ? q.lvl : release_step;
    n = q;
    if (apply) begin
      if (q.lvl < tgt) begin
        n.lvl = (up >= 33'(tgt)) ? tgt : up[31:0];
      end else if (q.lvl > tgt) begin
        n.lvl = ((q.lvl - tgt) <= rel) ? tgt : q.lvl - rel;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign level = q.lvl[31:16];
endmodule : scr_ff_ramp

//--- dv/scr_core_chk.sv
// port assertions of the speed command ramp core
`timescale 1ns/1ps
module scr_core_chk #(
  parameter int TICK_CYCLES = 300
) (
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire logic               reg_rd,
  input wire logic        [15:0] reg_rdata,
  input wire logic signed [15:0] measured_speed,
  input wire logic signed [15:0] speed_setpoint,
  input wire logic signed [15:0] ff_current,
  input wire logic               accel_ff_active,
  input wire logic               brake_ff_active
);
  logic signed [15:0] sp_q;
  logic signed [15:0] ff_q;
  logic        [15:0] sp_gap;
  logic        [15:0] ff_gap;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // cycles since each output last moved; a second move inside one tick is a fault
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sp_q   <= '0;
      ff_q   <= '0;
      sp_gap <= '0;
      ff_gap <= '0;
    end else begin
      sp_q   <= speed_setpoint;
      ff_q   <= ff_current;
      sp_gap <= (speed_setpoint != sp_q) ? 16'h0000 : sp_gap + 16'h0001;
      ff_gap <= (ff_current != ff_q) ? 16'h0000 : ff_gap + 16'h0001;
    end
  end

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside the read slot");
  a_reset_quiet: assert property ($rose(rstn) |->
    (speed_setpoint == 16'sh0000 && ff_current == 16'sh0000 && !accel_ff_active)[*8])
    else $error("outputs moved right after reset");
  a_sp_once_tick: assert property (speed_setpoint != sp_q |-> sp_gap >= TICK_CYCLES - 1)
    else $error("setpoint moved twice within one tick");
  a_ff_once_tick: assert property (ff_current != ff_q |-> ff_gap >= TICK_CYCLES - 1)
    else $error("feedforward moved twice within one tick");
  a_flags_apart: assert property (!(accel_ff_active && brake_ff_active))
    else $error("accel and brake terms built together");
  a_accel_rises: assert property (accel_ff_active && sp_q >= 0 && speed_setpoint != sp_q
    |-> speed_setpoint > sp_q)
    else $error("setpoint fell while accelerating");
  a_brake_falls: assert property (brake_ff_active && sp_q > 0 && speed_setpoint != sp_q
    |-> speed_setpoint < sp_q)
    else $error("setpoint rose while braking");
  a_acc_ff_up: assert property (accel_ff_active && measured_speed >= 0 && ff_current != ff_q
    |-> ff_current > ff_q)
    else $error("feedforward fell while accelerating forward");
  a_brk_ff_down: assert property (brake_ff_active && measured_speed > 0 && ff_current != ff_q
    |-> ff_current < ff_q)
    else $error("feedforward rose while braking forward");

  c_accel: cover property (accel_ff_active && speed_setpoint != sp_q);
  c_brake: cover property (brake_ff_active && ff_current != ff_q);
  c_read: cover property ($past(reg_rd) && reg_rdata != 16'h0000);
endmodule : scr_core_chk

//--- dv/scr_cmd_src.sv
// pedal source and motor speed stand-in facing the ramp core
`timescale 1ns/1ps
module scr_cmd_src (
  input  wire logic               core_clk,
  output logic signed      [15:0] throttle_cmd,
  output logic             [15:0] brake_cmd,
  output logic signed      [15:0] measured_speed
);
  initial begin
    throttle_cmd   = 16'sh0000;
    brake_cmd      = 16'h0000;
    measured_speed = 16'sh0000;
  end

  // values land just after an edge and then hold, as a pedal would
  task automatic drive(input logic signed [15:0] thr, input logic [15:0] brk,
                       input logic signed [15:0] spd);
    @(posedge core_clk);
    throttle_cmd   <= thr;
    brake_cmd      <= brk;
    measured_speed <= spd;
  endtask : drive
endmodule : scr_cmd_src

//--- dv/scr_core_tb.sv
// self-checking bench of the speed command ramp core
`timescale 1ns/1ps
module scr_core_tb;
  import scr_pkg::*;
  localparam int TICK  = 300;
  localparam int LIMIT = 15000;
  // short times so one tick is a whole rpm step: 4000 rpm over t ms
  localparam logic [15:0] CFG [SCR_NREG] = '{
    16'h000a, 16'h0004, 16'h00c8, 16'h0064, 16'h00c8, 16'h0190, 16'h00c8, 16'h0000,
    16'h0190, 16'h00c8, 16'h0190, 16'h0190, 16'h0320, 16'h5999, 16'h2666, 16'h0fa0};
  logic               core_clk;
  logic               rstn;
  logic        [15:0] reg_addr;
  logic        [15:0] reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic        [15:0] reg_rdata;
  logic signed [15:0] throttle_cmd;
  logic        [15:0] brake_cmd;
  logic signed [15:0] measured_speed;
  logic signed [15:0] speed_setpoint;
  logic signed [15:0] ff_current;
  logic               accel_ff_active;
  logic               brake_ff_active;
  int                 n_fail;
  int                 n_tests;
  int                 cyc = 0;

  scr_core #(.TICK_CYCLES(TICK)) dut_u (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .throttle_cmd(throttle_cmd), .brake_cmd(brake_cmd),
    .measured_speed(measured_speed), .speed_setpoint(speed_setpoint),
    .ff_current(ff_current), .accel_ff_active(accel_ff_active),
    .brake_ff_active(brake_ff_active));
  scr_cmd_src src_u (.core_clk(core_clk), .throttle_cmd(throttle_cmd),
    .brake_cmd(brake_cmd), .measured_speed(measured_speed));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      $display("[ERR] cycle_count expected below %0d seen %0d", LIMIT, cyc);
      give_verdict();
    end
  end

  task automatic cmp_reg(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_reg

  task automatic cmp_step(input string nm, input int lo, input int hi,
                          input logic signed [16:0] got);
    n_tests++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : cmp_step

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // two ticks for the new pedal state to take hold, then one tick measured
  task automatic measure(input logic signed [15:0] thr, input logic [15:0] brk,
                         input logic signed [15:0] spd, input string nm, input int lo,
                         input int hi, output logic signed [16:0] dff);
    logic signed [16:0] s0;
    logic signed [16:0] f0;
    src_u.drive(thr, brk, spd);
    repeat (2 * TICK) @(posedge core_clk);
    #1;
    s0 = 17'(speed_setpoint);
    f0 = 17'(ff_current);
    repeat (TICK) @(posedge core_clk);
    #1;
    cmp_step(nm, lo, hi, 17'(speed_setpoint) - s0);
    dff = 17'(ff_current) - f0;
  endtask : measure

  task automatic t_regs;
    logic [15:0] d;
    for (int i = 0; i < SCR_NREG; i++) begin
      reg_read(SCR_REG_ADDR[i], d);
      cmp_reg("reset_value", SCR_REG_RESET[i], d);
      reg_write(SCR_REG_ADDR[i], CFG[i]);
      reg_read(SCR_REG_ADDR[i], d);
      cmp_reg("readback", CFG[i], d);
    end
    reg_write(SCR_ADDR_STAT_SPEED, 16'h1234);
    reg_read(SCR_ADDR_STAT_SPEED, d);
    cmp_reg("status_write", 16'h0000, d);
    reg_read(16'h3000, d);
    cmp_reg("unmapped", 16'h0000, d);
    $display("test regs done");
  endtask : t_regs

  task automatic t_small_thr;
    logic signed [16:0] dff;
    measure(16'sh0100, 16'h0000, 16'sh0000, "small_thr_step", 9, 11, dff);
    cmp_reg("accel_ff_active", 16'h0001, 16'(accel_ff_active));
    $display("test small_thr done");
  endtask : t_small_thr

  task automatic t_accel_bands;
    logic signed [16:0] dff;
    measure(16'sh7fff, 16'h0000, 16'sh0000, "low_band_step", 39, 41, dff);
    cmp_step("ff_build_step", 19, 21, dff);
    measure(16'sh7fff, 16'h0000, 16'sh0fa0, "high_band_step", 19, 21, dff);
    measure(16'sh7fff, 16'h0000, 16'sh07d0, "mid_band_step", 22, 38, dff);
    cmp_reg("brake_ff_active", 16'h0000, 16'(brake_ff_active));
    $display("test accel_bands done");
  endtask : t_accel_bands

  task automatic t_coast;
    logic signed [16:0] dff;
    measure(16'sh0000, 16'h0000, 16'sh0000, "coast_low_step", -11, -9, dff);
    cmp_step("ff_release_step", -51, -49, dff);
    measure(16'sh0000, 16'h0000, 16'sh0fa0, "coast_high_step", -21, -19, dff);
    $display("test coast done");
  endtask : t_coast

  task automatic t_reduce;
    logic signed [16:0] dff;
    measure(16'sh0400, 16'h0000, 16'sh0000, "reduced_step", -11, -9, dff);
    cmp_reg("accel_ff_active", 16'h0000, 16'(accel_ff_active));
    $display("test reduce done");
  endtask : t_reduce

  task automatic t_brake;
    logic signed [16:0] dff;
    logic        [15:0] d;
    reg_write(SCR_REG_ADDR[SCR_I_BRK_FF], 16'h0064);
    measure(16'sh0000, 16'h7fff, 16'sh0000, "brake_low_step", -11, -9, dff);
    cmp_step("brake_ff_step", -11, -9, dff);
    cmp_reg("brake_ff_active", 16'h0001, 16'(brake_ff_active));
    measure(16'sh0000, 16'h7fff, 16'sh0fa0, "brake_high_step", -21, -19, dff);
    measure(16'sh0000, 16'h0001, 16'sh0fa0, "small_brake_step", -6, -4, dff);
    measure(16'sh8001, 16'h0000, 16'sh0fa0, "opp_thr_step", -21, -19, dff);
    reg_read(SCR_ADDR_STAT_MODE, d);
    cmp_reg("mode_status", 16'h000b, d);
    $display("test brake done");
  endtask : t_brake

  initial begin
    n_fail    = 0;
    n_tests   = 0;
    rstn      = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_small_thr();
    t_accel_bands();
    t_coast();
    t_reduce();
    t_brake();
    give_verdict();
  end
endmodule : scr_core_tb

bind scr_core scr_core_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.core_clk(core_clk),
  .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .measured_speed(measured_speed),
  .speed_setpoint(speed_setpoint), .ff_current(ff_current),
  .accel_ff_active(accel_ff_active), .brake_ff_active(brake_ff_active));
